/* src/dswc_params.svh */
// constants shared by both ends of the serial write link
`ifndef DSWC_PARAMS_SVH
`define DSWC_PARAMS_SVH

`define FRAME_BITS 18
`define CNT_W 5
`define CNT_MAX 5'h1f
`define OP_HI 17
`define OP_LO 16
`define ADDR_HI 15
`define ADDR_LO 12
`define CODE_HI 11
`define CODE_LO 0
`define OP_LOAD 2'b00
`define OP_INC 2'b01
`define OP_DEC 2'b10
`define OP_NOP 2'b11
`define CHANNELS 16
`define CHAN_W 4
`define LEVEL_W 14
`define LEVEL_RESET 14'h0000
`define LEVEL_MAX 15'h3fff
`define QUARTER_SHIFT 2
`define CLK_PERIOD_NS 25
`define CONV_TIME_NS 25000
`define RESET_MIN_NS 20
`define CONV_W 16

`define SCLK_HALF 6
`define GAP_CYCLES 16
`define TIMER_W 16

`define ADDR_W 12
`define REG_CTRL 12'h000
`define REG_FRAME 12'h004
`define REG_STATUS 12'h008
`define REG_INT_STAT 12'h00c
`define REG_INT_MASK 12'h010
`define REG_READBACK 12'h014
`define CTRL_START 0
`define STAT_ACTIVE 0
`define STAT_BUSY 1
`define STAT_PENDING 2
`define INT_W 2
`define INT_DONE 0
`define INT_CONV 1
`endif

/* src/dswc_pkg.sv */
// types shared by both ends of the serial write link
`include "dswc_params.svh"
package dswc_pkg;
    typedef logic [`LEVEL_W-1:0] dswc_level_t;
    typedef logic [`FRAME_BITS-1:0] dswc_frame_t;

    typedef struct packed {
        logic [2:0] sclkSync;
        logic [2:0] selSync;
        logic [2:0] dinSync;
        logic sclkF;
        logic selNF;
        logic dinF;
        logic active;
        logic [`CNT_W-1:0] count;
        dswc_frame_t shift;
        logic sdout;
        logic busyN;
        logic [`CONV_W-1:0] convCnt;
        logic [`CHANNELS-1:0][`LEVEL_W-1:0] level;
        logic updateStrobe;
        logic [`CHAN_W-1:0] updateChannel;
        logic abortStrobe;
    } dswc_dev_state_t;

    typedef enum logic [2:0] {
        H_IDLE,
        H_SETUP,
        H_HIGH,
        H_LOW,
        H_HOLD,
        H_GAP
    } dswc_phase_t;

    typedef struct packed {
        logic [2:0] busySync;
        logic [2:0] doutSync;
        logic busyNF;
        logic doutF;
        dswc_phase_t phase;
        logic [`TIMER_W-1:0] timer;
        logic [`CNT_W-1:0] idx;
        dswc_frame_t frame;
        dswc_frame_t txShift;
        dswc_frame_t readback;
        logic sclk;
        logic selN;
        logic sdin;
        logic startReq;
        logic [`INT_W-1:0] intStat;
        logic [`INT_W-1:0] intMask;
        logic [31:0] prdata;
        logic pslverr;
    } dswc_host_state_t;
endpackage

/* src/dswc_link_if.sv */
// three-wire write link plus busy and chain output
`timescale 1ns/10ps
interface dswc_link_if;
    logic sclk;
    logic syncN;
    logic sdin;
    logic sdout;
    logic busyN;

    modport host (
        output sclk,
        output syncN,
        output sdin,
        input sdout,
        input busyN
    );

    modport device (
        input sclk,
        input syncN,
        input sdin,
        output sdout,
        output busyN
    );
endinterface

/* src/dswc_device.sv */
// device end: serial frame receiver and sixteen channel code store
`timescale 1ns/10ps
`include "dswc_params.svh"
module dswc_device
    import dswc_pkg::*;
#(
    parameter int CONV_CYCLES = `CONV_TIME_NS / `CLK_PERIOD_NS
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic chainEnable,
    dswc_link_if.device link,
    output logic [`CHANNELS-1:0][`LEVEL_W-1:0] channelLevel,
    output logic convBusy,
    output logic updateStrobe,
    output logic [`CHAN_W-1:0] updateChannel,
    output logic abortStrobe
);

    dswc_dev_state_t r_reg;
    dswc_dev_state_t r_next;

    logic sclkFall;
    logic sclkRise;
    logic selFall;
    logic selRise;
    logic commitNow;
    dswc_frame_t commitWord;
    dswc_frame_t shifted;
    logic [1:0] op;
    logic [`CHAN_W-1:0] addr;
    logic [`CONV_W-1:0] convLoad;

    assign convLoad = `CONV_W'(CONV_CYCLES - 1);

    // settled level: third stage taken once second and third agree
    function automatic logic settle(input logic [2:0] s, input logic held);
        return (s[1] == s[2]) ? s[2] : held;
    endfunction

    // new fine level of one channel for a committed word
    function automatic dswc_level_t stepLevel(input dswc_level_t cur, input dswc_frame_t w);
        logic [`LEVEL_W:0] sum;
        logic [`LEVEL_W:0] step;
        dswc_level_t res;
        sum = '0;
        step = {3'b000, w[`CODE_HI:`CODE_LO]};
        res = cur;
        unique case (w[`OP_HI:`OP_LO])
            `OP_LOAD: begin
                res = {w[`CODE_HI:`CODE_LO], 2'b00};
            end
            `OP_INC: begin
                sum = {1'b0, cur} + step;
                res = sum[`LEVEL_W] ? {`LEVEL_W{1'b1}} : sum[`LEVEL_W-1:0];
            end
            `OP_DEC: begin
                res = ({1'b0, cur} < step) ? `LEVEL_RESET : cur - step[`LEVEL_W-1:0];
            end
            `OP_NOP: begin
                res = cur;
            end
        endcase
        return res;
    endfunction

    always_comb begin
        r_next = r_reg;
        commitNow = 1'b0;
        commitWord = r_reg.shift;
        shifted = {r_reg.shift[`FRAME_BITS-2:0], r_reg.dinF};
        op = 2'b00;
        addr = '0;

        r_next.updateStrobe = 1'b0;
        r_next.abortStrobe = 1'b0;

        // pin synchronisers and settled levels
        r_next.sclkSync = {r_reg.sclkSync[1:0], link.sclk};
        r_next.selSync = {r_reg.selSync[1:0], link.syncN};
        r_next.dinSync = {r_reg.dinSync[1:0], link.sdin};
        r_next.sclkF = settle(r_reg.sclkSync, r_reg.sclkF);
        r_next.selNF = settle(r_reg.selSync, r_reg.selNF);
        r_next.dinF = settle(r_reg.dinSync, r_reg.dinF);

        sclkFall = r_reg.sclkF & ~r_next.sclkF;
        sclkRise = ~r_reg.sclkF & r_next.sclkF;
        selFall = r_reg.selNF & ~r_next.selNF;
        selRise = ~r_reg.selNF & r_next.selNF;

        // conversion timer holds busy low
        if (!r_reg.busyN) begin
            if (r_reg.convCnt == '0) begin
                r_next.busyN = 1'b1;
            end else begin
                r_next.convCnt = r_reg.convCnt - 1'b1;
            end
        end

        // link activity only seen while not converting
        if (r_reg.busyN) begin
            if (selFall) begin
                r_next.active = 1'b1;
                r_next.count = '0;
            end else if (selRise) begin
                if (r_reg.active) begin
                    if (chainEnable && r_reg.count >= `CNT_W'(`FRAME_BITS)) begin
                        commitNow = 1'b1;
                        commitWord = r_reg.shift;
                    end else if (!chainEnable || r_reg.count < `CNT_W'(`FRAME_BITS)) begin
                        r_next.abortStrobe = 1'b1;
                    end
                end
                r_next.active = 1'b0;
            end else if (r_reg.active && sclkFall) begin
                r_next.shift = shifted;
                if (r_reg.count != `CNT_MAX) begin
                    r_next.count = r_reg.count + 1'b1;
                end
                if (!chainEnable && r_reg.count == `CNT_W'(`FRAME_BITS - 1)) begin
                    commitNow = 1'b1;
                    commitWord = shifted;
                    r_next.active = 1'b0;
                end
            end else if (r_reg.active && sclkRise && chainEnable) begin
                r_next.sdout = r_reg.shift[`FRAME_BITS-1];
            end
        end

        if (!chainEnable) begin
            r_next.sdout = 1'b0;
        end

        // apply a completed frame to its channel
        if (commitNow) begin
            op = commitWord[`OP_HI:`OP_LO];
            addr = commitWord[`ADDR_HI:`ADDR_LO];
            if (op != `OP_NOP) begin
                r_next.level[addr] = stepLevel(r_reg.level[addr], commitWord);
                r_next.updateStrobe = 1'b1;
                r_next.updateChannel = addr;
            end
            if (op == `OP_LOAD) begin
                r_next.busyN = 1'b0;
                r_next.convCnt = convLoad;
            end
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            r_reg.sclkSync <= 3'h0;
            r_reg.selSync <= 3'h7;
            r_reg.dinSync <= 3'h0;
            r_reg.sclkF <= 1'b0;
            r_reg.selNF <= 1'b1;
            r_reg.dinF <= 1'b0;
            r_reg.active <= 1'b0;
            r_reg.count <= '0;
            r_reg.shift <= '0;
            r_reg.sdout <= 1'b0;
            r_reg.busyN <= 1'b1;
            r_reg.convCnt <= '0;
            r_reg.level <= {`CHANNELS{`LEVEL_RESET}};
            r_reg.updateStrobe <= 1'b0;
            r_reg.updateChannel <= '0;
            r_reg.abortStrobe <= 1'b0;
        end else begin
            r_reg <= r_next;
        end
    end

    assign link.sdout = r_reg.sdout;
    assign link.busyN = r_reg.busyN;
    assign channelLevel = r_reg.level;
    assign convBusy = ~r_reg.busyN;
    assign updateStrobe = r_reg.updateStrobe;
    assign updateChannel = r_reg.updateChannel;
    assign abortStrobe = r_reg.abortStrobe;

endmodule // dswc_device

/* src/dswc_host.sv */
// host end: apb-controlled serial frame sender
//
// Register access over APB and the address map were decided locally.
`timescale 1ns/10ps
`include "dswc_params.svh"
module dswc_host
    import dswc_pkg::*;
#(
    parameter int SCLK_HALF = `SCLK_HALF,
    parameter int GAP = `GAP_CYCLES
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [`ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic irq,
    dswc_link_if.host link
);

    dswc_host_state_t r_reg;
    dswc_host_state_t r_next;
    logic [`TIMER_W-1:0] halfLoad;
    logic [`TIMER_W-1:0] gapLoad;
    logic wrAccess;
    logic [`INT_W-1:0] events;

    assign halfLoad = `TIMER_W'(SCLK_HALF - 1);
    assign gapLoad = `TIMER_W'(GAP - 1);
    assign wrAccess = psel & penable & pwrite;

    always_comb begin
        r_next = r_reg;
        events = '0;
        r_next.busySync = {r_reg.busySync[1:0], link.busyN};
        r_next.doutSync = {r_reg.doutSync[1:0], link.sdout};
        if (r_reg.busySync[1] == r_reg.busySync[2]) begin
            r_next.busyNF = r_reg.busySync[2];
        end
        if (r_reg.doutSync[1] == r_reg.doutSync[2]) begin
            r_next.doutF = r_reg.doutSync[2];
        end
        if (!r_reg.busyNF && r_next.busyNF) begin
            events[`INT_CONV] = 1'b1;
        end

        // read data prepared in setup cycle
        if (psel && !penable) begin
            r_next.pslverr = 1'b0;
            r_next.prdata = '0;
            unique case (paddr)
                `REG_CTRL: r_next.prdata = '0;
                `REG_FRAME: r_next.prdata = {14'h0000, r_reg.frame};
                `REG_STATUS: begin
                    r_next.prdata[`STAT_ACTIVE] = (r_reg.phase != H_IDLE);
                    r_next.prdata[`STAT_BUSY] = ~r_reg.busyNF;
                    r_next.prdata[`STAT_PENDING] = r_reg.startReq;
                end
                `REG_INT_STAT: r_next.prdata = {30'h00000000, r_reg.intStat};
                `REG_INT_MASK: r_next.prdata = {30'h00000000, r_reg.intMask};
                `REG_READBACK: r_next.prdata = {14'h0000, r_reg.readback};
                default: r_next.pslverr = 1'b1;
            endcase
        end

        if (wrAccess) begin
            unique case (paddr)
                `REG_CTRL: begin
                    if (pwdata[`CTRL_START]) begin
                        r_next.startReq = 1'b1;
                    end
                end
                `REG_FRAME: r_next.frame = pwdata[`FRAME_BITS-1:0];
                `REG_INT_STAT: r_next.intStat = r_reg.intStat & ~pwdata[`INT_W-1:0];
                `REG_INT_MASK: r_next.intMask = pwdata[`INT_W-1:0];
                default: r_next.intMask = r_reg.intMask;
            endcase
        end

        unique case (r_reg.phase)
            H_IDLE: begin
                if (r_reg.startReq && r_reg.busyNF) begin
                    r_next.startReq = 1'b0;
                    r_next.selN = 1'b0;
                    r_next.txShift = r_reg.frame;
                    r_next.idx = '0;
                    r_next.timer = halfLoad;
                    r_next.phase = H_SETUP;
                end
            end
            H_SETUP: begin
                if (r_reg.timer == '0) begin
                    r_next.sclk = 1'b1;
                    r_next.sdin = r_reg.txShift[`FRAME_BITS-1];
                    r_next.timer = halfLoad;
                    r_next.phase = H_HIGH;
                end else begin
                    r_next.timer = r_reg.timer - 1'b1;
                end
            end
            H_HIGH: begin
                if (r_reg.timer == '0) begin
                    r_next.sclk = 1'b0;
                    r_next.timer = halfLoad;
                    r_next.phase = H_LOW;
                end else begin
                    r_next.timer = r_reg.timer - 1'b1;
                end
            end
            H_LOW: begin
                if (r_reg.timer == '0) begin
                    r_next.readback = {r_reg.readback[`FRAME_BITS-2:0], r_reg.doutF};
                    r_next.timer = halfLoad;
                    if (r_reg.idx == `CNT_W'(`FRAME_BITS - 1)) begin
                        r_next.phase = H_HOLD;
                    end else begin
                        r_next.idx = r_reg.idx + 1'b1;
                        r_next.txShift = {r_reg.txShift[`FRAME_BITS-2:0], 1'b0};
                        r_next.sclk = 1'b1;
                        r_next.sdin = r_reg.txShift[`FRAME_BITS-2];
                        r_next.phase = H_HIGH;
                    end
                end else begin
                    r_next.timer = r_reg.timer - 1'b1;
                end
            end
            H_HOLD: begin
                if (r_reg.timer == '0) begin
                    r_next.selN = 1'b1;
                    events[`INT_DONE] = 1'b1;
                    r_next.timer = gapLoad;
                    r_next.phase = H_GAP;
                end else begin
                    r_next.timer = r_reg.timer - 1'b1;
                end
            end
            H_GAP: begin
                if (r_reg.timer == '0) begin
                    r_next.phase = H_IDLE;
                end else begin
                    r_next.timer = r_reg.timer - 1'b1;
                end
            end
        endcase

        // set wins over write-one clear
        r_next.intStat = r_next.intStat | events;
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            r_reg <= '0;
            r_reg.busySync <= 3'h7;
            r_reg.busyNF <= 1'b1;
            r_reg.selN <= 1'b1;
            r_reg.phase <= H_IDLE;
        end else begin
            r_reg <= r_next;
        end
    end

    assign prdata = r_reg.prdata;
    assign pslverr = r_reg.pslverr;
    assign pready = psel & penable;
    assign irq = |(r_reg.intStat & r_reg.intMask);
    assign link.sclk = r_reg.sclk;
    assign link.syncN = r_reg.selN;
    assign link.sdin = r_reg.sdin;

endmodule // dswc_host

/* verification/dswc_link_properties.sv */
// rule checker watching the host-to-device serial write link
`timescale 1ns/10ps
`include "dswc_params.svh"
module dswc_link_properties #(
    parameter int CONV_CYCLES = `CONV_TIME_NS / `CLK_PERIOD_NS
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic sclk,
    input wire logic syncN,
    input wire logic sdin,
    input wire logic sdout,
    input wire logic busyN
);
    logic sclkQ;
    logic [4:0] falls;
    logic [17:0] word;
    int lowCnt;

    // falls and frame word seen on the wire, busy low length
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sclkQ <= 1'b0;
            falls <= 5'h00;
            word <= 18'h00000;
            lowCnt <= 0;
        end else begin
            sclkQ <= sclk;
            falls <= syncN ? 5'h00 : falls + {4'h0, sclkQ & ~sclk};
            word <= (sclkQ & ~sclk) ? {word[16:0], sdin} : word;
            lowCnt <= busyN ? 0 : lowCnt + 1;
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);

    sequence s_quiet;
        syncN [*8];
    endsequence
    sequence s_busy_soon;
        ##[0:8] !busyN;
    endsequence

    a_reset_idle: assert property ($rose(nrst) |-> busyN && syncN && !sdout)
        else $error("link not idle after reset");
    a_frame_len: assert property ($rose(syncN) |-> falls == 5'h12)
        else $error("frame without 18 clock falls");
    a_sel_in_frame: assert property ($fell(sclk) |-> !syncN)
        else $error("clock fall outside frame");
    a_sel_gap: assert property ($rose(syncN) |-> s_quiet)
        else $error("select lowered too soon");
    a_data_stable: assert property ($fell(sclk) |-> $stable(sdin))
        else $error("data moved at clock fall");
    a_clk_idle: assert property (syncN |-> !sclk)
        else $error("clock not idle low");
    a_clk_still: assert property (!busyN |-> $stable(sclk))
        else $error("clock toggled while busy");
    a_busy_len: assert property ($rose(busyN) |-> lowCnt == CONV_CYCLES)
        else $error("busy low time wrong");
    a_busy_cap: assert property (!busyN |-> lowCnt < CONV_CYCLES)
        else $error("busy low too long");
    a_load_busy: assert property ($rose(syncN) && word[17:16] == 2'b00 |-> s_busy_soon)
        else $error("load without conversion");
    a_other_idle: assert property ($rose(syncN) && word[17:16] != 2'b00 |-> busyN [*8])
        else $error("busy on non-load frame");
endmodule // dswc_link_properties

/* verification/test_dswc_serial_write_control.sv */
// self-checking bench: host and device joined, second device driven by bench
`timescale 1ns/10ps
`include "dswc_params.svh"
`define CHK(g, e) begin checkCount++; if ((g) !== (e)) begin fails++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module test_dswc_serial_write_control import dswc_pkg::*; ;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr, irq, updStb, abortA, abortB, sawAbort, sawUpd, convB;
    logic chainEnable = 1'b0;
    logic [3:0] updCh;
    logic [15:0][13:0] channelLevel, levelB, model;
    logic [31:0] rd;
    logic err;
    int fails = 0;
    int checkCount = 0;
    int cycles = 0;

    dswc_link_if link();
    dswc_link_if linkB();
    always #12.5 clk = ~clk;

    dswc_host u_dswc_host (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .irq(irq), .link(link));
    dswc_device #(.CONV_CYCLES(20)) u_dswc_device (.clk(clk), .nrst(nrst),
        .chainEnable(chainEnable), .link(link), .channelLevel(channelLevel), .convBusy(),
        .updateStrobe(updStb), .updateChannel(updCh), .abortStrobe(abortA));
    dswc_device #(.CONV_CYCLES(400)) u_dswc_device_b (.clk(clk), .nrst(nrst),
        .chainEnable(1'b0), .link(linkB), .channelLevel(levelB), .convBusy(convB),
        .updateStrobe(), .updateChannel(), .abortStrobe(abortB));
    dswc_link_properties #(.CONV_CYCLES(20)) u_props (.clk(clk), .nrst(nrst),
        .sclk(link.sclk), .syncN(link.syncN), .sdin(link.sdin), .sdout(link.sdout),
        .busyN(link.busyN));

    task automatic end_sim;
        $display("errors=%0d checks=%0d", fails, checkCount);
        if (fails == 0 && checkCount > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    always @(posedge clk) begin
        cycles++;
        if (abortB === 1'b1) sawAbort <= 1'b1;
        if (updStb === 1'b1) sawUpd <= 1'b1;
        if (cycles > 30000) begin
            fails++;
            end_sim;
        end
    end

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) begin
            @(posedge clk);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask

    task automatic send(input logic [17:0] f);
        int n;
        n = 0;
        apb(1'b1, `REG_INT_STAT, 32'h3);
        apb(1'b1, `REG_FRAME, {14'h0, f});
        apb(1'b1, `REG_CTRL, 32'h1);
        rd = 32'h0;
        while (rd[0] !== 1'b1 && n < 400) begin
            apb(1'b0, `REG_INT_STAT, 32'h0);
            n++;
        end
        // commit and busy take a few cycles to show
        repeat (8) @(posedge clk);
        while (link.busyN !== 1'b1 && n < 500) begin
            @(posedge clk);
            n++;
        end
        `CHK(link.busyN, 1'b1)
    endtask

    task automatic t_frame(input logic [1:0] op, input logic [3:0] ch, input logic [11:0] code);
        logic [14:0] s;
        s = {1'b0, model[ch]} + {3'h0, code};
        case (op)
            2'b00: model[ch] = {code, 2'b00};
            2'b01: model[ch] = s[14] ? 14'h3fff : s[13:0];
            2'b10: model[ch] = (model[ch] < code) ? 14'h0 : model[ch] - code;
            default: ;
        endcase
        sawUpd <= 1'b0;
        send({op, ch, code});
        `CHK(channelLevel, model)
        `CHK(sawUpd, op != 2'b11)
        if (op != 2'b11) `CHK(updCh, ch)
    endtask

    task automatic bframe(input logic [17:0] f, input int nb);
        linkB.syncN <= 1'b0;
        repeat (4) @(posedge clk);
        for (int i = 17; i > 17 - nb; i--) begin
            linkB.sclk <= 1'b1;
            linkB.sdin <= f[i];
            repeat (4) @(posedge clk);
            linkB.sclk <= 1'b0;
            repeat (4) @(posedge clk);
        end
        linkB.syncN <= 1'b1;
        linkB.sdin <= ~linkB.sdin;
        repeat (16) @(posedge clk);
    endtask

    task automatic t_reset;
        `CHK(channelLevel, 224'h0)
        `CHK({link.busyN, link.syncN, link.sclk, link.sdout}, 4'hc)
        apb(1'b0, 12'h020, 32'h0);
        `CHK({err, rd}, 33'h100000000)
    endtask

    task automatic t_irq;
        apb(1'b1, `REG_INT_MASK, 32'h0);
        apb(1'b0, `REG_INT_STAT, 32'h0);
        `CHK(rd[1:0], 2'b11)
        `CHK(irq, 1'b0)
        apb(1'b1, `REG_INT_MASK, 32'h2);
        `CHK(irq, 1'b1)
        apb(1'b1, `REG_INT_STAT, 32'h1);
        `CHK(irq, 1'b1)
        apb(1'b1, `REG_INT_STAT, 32'h2);
        `CHK(irq, 1'b0)
    endtask

    task automatic t_chain;
        chainEnable <= 1'b1;
        t_frame(2'b00, 4'h7, 12'h123);
        t_frame(2'b00, 4'h8, 12'h456);
        apb(1'b0, `REG_READBACK, 32'h0);
        `CHK(rd[17:0], 18'h07123)
        chainEnable <= 1'b0;
    endtask

    task automatic t_devb;
        int n;
        n = 0;
        sawAbort <= 1'b0;
        bframe(18'h02555, 5);
        `CHK({sawAbort, levelB[2]}, 15'h4000)
        bframe(18'h03abc, 18);
        `CHK({linkB.busyN, convB}, 2'b01)
        bframe(18'h03123, 18);
        `CHK(levelB[3], 14'h2af0)
        while (linkB.busyN !== 1'b1 && n < 500) begin
            @(posedge clk);
            n++;
        end
        `CHK(linkB.busyN, 1'b1)
        bframe(18'h03123, 18);
        `CHK(levelB[3], 14'h048c)
    endtask

    initial begin
        model = '0;
        linkB.sclk = 1'b0;
        linkB.syncN = 1'b1;
        linkB.sdin = 1'b0;
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        t_reset;
        t_frame(2'b00, 4'h0, 12'hfff);
        t_irq;
        t_frame(2'b00, 4'hf, 12'habc);
        t_frame(2'b01, 4'hf, 12'h003);
        t_frame(2'b10, 4'hf, 12'h001);
        t_frame(2'b11, 4'hf, 12'h7ff);
        t_frame(2'b01, 4'h0, 12'hfff);
        t_frame(2'b10, 4'hf, 12'hfff);
        t_chain;
        t_devb;
        end_sim;
    end
endmodule // test_dswc_serial_write_control
